// *** hw/fspc_top.sv ***
/*
 * Flash self-program control: unlock-protected mode register, protect
 * byte readback, halt-triggered flash operation with automatic release.
 * Assumes an AXI4-Lite master on aclk and a flash array beside it that
 * answers the operation handshake; the CPU honours cpu_stall.
 */
// Register access over AXI4-Lite is this design's own decision.
// Functional notes
// RULE_01: Stall CPU while flash command runs
// RULE_02: Hold interrupts pending during self-program mode
// RULE_03: Erased bytes read all ones
// RULE_04: First halt released within 10us plus 2
// RULE_05: Software waits 8us before first command
// RULE_06: Software keeps CPU clock at least 1MHz
// RULE_07: Pins freeze as in halt standby
// RULE_08: Only protect byte inhibits write or erase
// RULE_09: Software zeroes upper address pointer bits
// RULE_10: Software zeroes command before each mode switch
// RULE_11: Protect byte lives at fixed flash location
// RULE_12: Mode register layout, readback bits read-only
// RULE_13: Reset clears select, loads protect readback
// RULE_14: Select zero: halt is plain standby
// RULE_15: Select one: halt starts loaded flash operation
// RULE_16: Key, value, inverse, value unlocks update
// RULE_17: Bad sequence keeps register, sets error
// RULE_18: Software masks interrupts across the switch
// RULE_19: No RAM access during flash command
// RULE_20: Key write-only; mode register byte stores only
// RULE_21: Foreign store mid-sequence sets error flag
// RULE_22: Error cleared only by zero write, reset
// RULE_23: Halt released automatically after operation
// RULE_24: Tracker returns idle after each attempt
`default_nettype none
`include "fspc_regs.svh"

module fspc_top #(
  parameter int REL_NS = `FSPC_REL_NS,   // First-release limit in ns
  parameter int OP_CYC = `FSPC_OP_CYC    // Flash operation length
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`FSPC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`FSPC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   halt_req,
  input  wire logic [4:0]             prot_byte,
  input  wire logic                   irq_in,
  output logic                        irq_out,
  output logic                        cpu_stall,
  output logic                        pin_freeze,
  output logic                        ram_block,
  output logic                        flash_start,
  output logic [`FSPC_CMD_W-1:0]      flash_cmd,
  output logic [7:0]                  blank_value,
  output logic [15:0]                 prot_loc,
  input  wire logic                   flash_done
);
  localparam int REL_CYC =
    (REL_NS * (`FSPC_CLK_HZ / 1000000)) / 1000 + `FSPC_REL_EXTRA;
  localparam int CW = 16;

  // Elaboration guard: the release compare needs at least two cycles
  if (OP_CYC < 1 || REL_CYC < 2 || REL_CYC >= (1 << CW)) begin : g_bad_cfg
    $error("fspc_top: counts out of range");
  end

  // Registered state
  logic                  sel_r;           // Mode select
  logic [4:0]            rb_r;            // Protect readback
  logic                  err_r;           // Protection error
  logic [`FSPC_CMD_W-1:0] cmd_r;          // Flash command
  logic                  first_r;         // First halt after entry
  fspc_pkg::fspc_seq_e   seq_r;           // Unlock tracker
  fspc_pkg::fspc_op_e    op_r;            // Flash sequencer
  logic [CW-1:0]         cnt_r;           // Release timer
  logic                  rel_r;           // Halt released pulse
  logic [7:0]            want_r;          // Value held for compare
  logic                  rb_load_r;       // Readback capture pending

  // Write channel handshake: take address and data together
  logic          wr_go;
  fspc_pkg::fspc_store_s st;
  logic          mapped_w;
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign st.valid = wr_go & s_axi_wstrb[0];
  assign st.idx   = s_axi_awaddr[`FSPC_ADDR_W-1:2];
  assign st.data  = s_axi_wdata[7:0];
  assign mapped_w = (st.idx == `FSPC_IDX_KEY) ||
                    (st.idx == `FSPC_IDX_STATUS) ||
                    (st.idx == `FSPC_IDX_MODE) ||
                    (st.idx == `FSPC_IDX_CMD);

  // Write response, one cycle after take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FSPC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped_w ? `FSPC_RESP_OKAY : `FSPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Store classification
  logic to_key, to_mode, mode_full;
  assign to_key    = st.valid && st.idx == `FSPC_IDX_KEY;
  assign to_mode   = st.valid && st.idx == `FSPC_IDX_MODE;
  assign mode_full = s_axi_wstrb[0];  // Low lane holds the byte store

  // Unlock tracker; every attempt ends in idle
  logic seq_fail, seq_ok;
  always_comb begin
    seq_fail = 1'b0;
    seq_ok   = 1'b0;
    case (seq_r)
      fspc_pkg::FSPC_IDLE: seq_fail = to_mode;          // see RULE_17
      fspc_pkg::FSPC_KEYD: seq_fail = st.valid & ~to_mode; // see RULE_21
      fspc_pkg::FSPC_VAL1: seq_fail = st.valid &
        (~to_mode | (st.data != ~want_r));               // see RULE_21
      fspc_pkg::FSPC_INV: begin
        seq_fail = st.valid & (~to_mode | (st.data != want_r));
        seq_ok   = to_mode & (st.data == want_r);        // see RULE_16
      end
      default: seq_fail = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_r  <= fspc_pkg::FSPC_IDLE;
      want_r <= 8'h00;
    end else if (seq_fail || seq_ok) begin
      seq_r <= fspc_pkg::FSPC_IDLE;                      // see RULE_24
    end else begin
      case (seq_r)
        fspc_pkg::FSPC_IDLE:
          if (to_key && st.data == `FSPC_KEY_VAL)
            seq_r <= fspc_pkg::FSPC_KEYD;                // see RULE_16
        fspc_pkg::FSPC_KEYD:
          if (to_mode) begin
            seq_r  <= fspc_pkg::FSPC_VAL1;
            want_r <= st.data;
          end
        fspc_pkg::FSPC_VAL1:
          if (to_mode) seq_r <= fspc_pkg::FSPC_INV;
        // Idle bus cycles between stores must not drop the attempt
        fspc_pkg::FSPC_INV:
          seq_r <= fspc_pkg::FSPC_INV;                   // see RULE_16
        default: seq_r <= fspc_pkg::FSPC_IDLE;
      endcase
    end
  end

  // Mode select: only the final store of a clean sequence lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r <= 1'b0;                                     // see RULE_13
    end else if (seq_ok && mode_full) begin
      sel_r <= st.data[`FSPC_MODE_SEL];                  // see RULE_16
    end
  end

  // Protect readback captured after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rb_load_r <= 1'b1;
      rb_r      <= 5'h00;
    end else if (rb_load_r) begin
      rb_load_r <= 1'b0;
      rb_r      <= prot_byte;                            // see RULE_13
    end
  end

  // Error flag: set wins over the zero-write clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_r <= 1'b0;
    end else if (seq_fail) begin
      err_r <= 1'b1;                                     // see RULE_17
    end else if (st.valid && st.idx == `FSPC_IDX_STATUS &&
                 !st.data[`FSPC_ERR_BIT]) begin
      err_r <= 1'b0;                                     // see RULE_22
    end
  end

  // Command register, cleared by software before mode switches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= 3'h0;
    end else if (st.valid && st.idx == `FSPC_IDX_CMD) begin
      cmd_r <= st.data[`FSPC_CMD_W-1:0];                 // see RULE_10
    end
  end

  // Halt-driven sequencer
  logic halt_start;
  assign halt_start = halt_req & sel_r &
                      (op_r == fspc_pkg::FSPC_RUN);      // see RULE_15
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_r    <= fspc_pkg::FSPC_RUN;
      cnt_r   <= '0;
      first_r <= 1'b1;
      rel_r   <= 1'b0;
    end else begin
      rel_r <= 1'b0;
      if (!sel_r) first_r <= 1'b1;
      case (op_r)
        fspc_pkg::FSPC_RUN:
          if (halt_start) begin
            op_r  <= fspc_pkg::FSPC_BUSY;
            cnt_r <= '0;
          end
        fspc_pkg::FSPC_BUSY: begin
          cnt_r <= cnt_r + 1'b1;
          // First halt is a settle, not a flash operation
          if (first_r ? (cnt_r == CW'(REL_CYC - 2))      // see RULE_04
                      : flash_done) begin                // see RULE_23
            op_r    <= fspc_pkg::FSPC_DONE;
            first_r <= 1'b0;
          end
        end
        fspc_pkg::FSPC_DONE: begin
          op_r  <= fspc_pkg::FSPC_RUN;
          rel_r <= 1'b1;
        end
        default: op_r <= fspc_pkg::FSPC_RUN;
      endcase
    end
  end

  // Outputs toward CPU and flash array
  assign cpu_stall   = (op_r != fspc_pkg::FSPC_RUN);   // see RULE_01
  assign ram_block   = cpu_stall & ~first_r;           // see RULE_19
  assign pin_freeze  = sel_r | (halt_req & ~sel_r);    // see RULE_07
  assign irq_out     = irq_in & ~sel_r;                // see RULE_02
  // Security from external programming is not consulted here;
  // the protect byte itself gates the array's write path
  assign flash_start = halt_start & ~first_r;          // see RULE_08
  assign flash_cmd   = cmd_r;                          // see RULE_14
  assign blank_value = `FSPC_BLANK;                    // see RULE_03
  assign prot_loc    = `FSPC_PROT_LOC;                 // see RULE_11

  // Read channel; key register reads zero
  logic [7:0] rd_byte;
  logic       rd_map;
  logic [15:0] ridx;
  assign ridx = s_axi_araddr[`FSPC_ADDR_W-1:2];
  always_comb begin
    rd_byte = 8'h00;
    rd_map  = 1'b1;
    case (ridx)
      `FSPC_IDX_KEY:    rd_byte = 8'h00;               // see RULE_20
      `FSPC_IDX_STATUS: rd_byte = {7'h00, err_r};
      `FSPC_IDX_MODE:   rd_byte = {1'b0, rb_r, 1'b0, sel_r}; // see RULE_12
      `FSPC_IDX_CMD:    rd_byte = {5'h00, cmd_r};
      `FSPC_IDX_CTRL:   rd_byte = {5'h00, op_r, first_r};
      default:          rd_map  = 1'b0;
    endcase
  end
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `FSPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h0, rd_byte};
      s_axi_rresp  <= rd_map ? `FSPC_RESP_OKAY : `FSPC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Assertions
  // Steps of the unlock and of the automatic release
  sequence s_key_taken;
    to_key && st.data == `FSPC_KEY_VAL && seq_r == fspc_pkg::FSPC_IDLE;
  endsequence
  sequence s_key_armed;
    seq_r == fspc_pkg::FSPC_KEYD;
  endsequence
  sequence s_op_done;
    op_r == fspc_pkg::FSPC_DONE;
  endsequence

  a_mode_lock: assert property (                        // see RULE_16
    @(posedge aclk) disable iff (!aresetn)
    $changed(sel_r) |-> $past(seq_ok))
    else $error("mode changed without unlock");
  a_key_arms: assert property (                         // see RULE_16
    @(posedge aclk) disable iff (!aresetn)
    s_key_taken |=> s_key_armed)
    else $error("key did not arm tracker");
  a_err_set: assert property (                          // see RULE_17
    @(posedge aclk) disable iff (!aresetn)
    seq_fail |=> err_r)
    else $error("error flag not set");
  a_err_hold: assert property (                         // see RULE_22
    @(posedge aclk) disable iff (!aresetn)
    $fell(err_r) |-> $past(st.valid) &&
      $past(st.idx) == `FSPC_IDX_STATUS &&
      !$past(st.data[`FSPC_ERR_BIT]))
    else $error("error flag cleared wrongly");
  a_seq_idle: assert property (                         // see RULE_24
    @(posedge aclk) disable iff (!aresetn)
    (seq_fail || seq_ok) |=> seq_r == fspc_pkg::FSPC_IDLE)
    else $error("tracker not idle");
  a_stall_busy: assert property (                       // see RULE_01
    @(posedge aclk) disable iff (!aresetn)
    halt_start |=> cpu_stall)
    else $error("cpu not stalled");
  a_irq_hold: assert property (                         // see RULE_02
    @(posedge aclk) disable iff (!aresetn)
    sel_r |-> !irq_out)
    else $error("irq passed in self mode");
  a_first_rel: assert property (                        // see RULE_04
    @(posedge aclk) disable iff (!aresetn)
    (halt_start && first_r) |-> ##[1:1000] rel_r)
    else $error("first halt not released");
  // Done from the array leads to one release cycle, then the CPU runs
  a_auto_rel: assert property (                         // see RULE_23
    @(posedge aclk) disable iff (!aresetn)
    (op_r == fspc_pkg::FSPC_BUSY && !first_r && flash_done) |=>
    s_op_done ##1 !cpu_stall)
    else $error("halt not released after operation");
  // A plain standby halt neither starts the array nor stalls the CPU
  a_no_start: assert property (                         // see RULE_14
    @(posedge aclk) disable iff (!aresetn)
    (halt_req && !sel_r && !cpu_stall) |-> !flash_start ##1 !cpu_stall)
    else $error("flash started in normal mode");
  a_mode_read: assert property (                        // see RULE_12
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && $past(ridx) == `FSPC_IDX_MODE &&
    $past(s_axi_arvalid && s_axi_arready) |->
    s_axi_rdata[7] == 1'b0 && s_axi_rdata[1] == 1'b0)
    else $error("mode reserved bits set");
endmodule
`default_nettype wire

// *** hw/fspc_regs.svh ***
/*
 * Register map and timing constants for the flash self-program control.
 * Assumes a 10 MHz aclk and an AXI4-Lite slave with 32-bit data.
 */
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH

// Register indexes (printed offsets are multiples of four only in part,
// so every printed offset is an index and the byte address is 4x)
`define FSPC_IDX_KEY      16'hffa0
`define FSPC_IDX_STATUS   16'hffa1
`define FSPC_IDX_MODE     16'hffa2
`define FSPC_IDX_CMD      16'hffa3
`define FSPC_IDX_CTRL     16'hffa4
`define FSPC_ADDR_W       18

// Field positions
`define FSPC_MODE_SEL     0
`define FSPC_RB_LO        2
`define FSPC_RB_HI        6
`define FSPC_ERR_BIT      0
`define FSPC_CMD_W        3

// Values
`define FSPC_KEY_VAL      8'ha5
`define FSPC_BLANK        8'hff
`define FSPC_PROT_LOC     16'h0081
`define FSPC_CMD_ERASE    3'h3
`define FSPC_CMD_WRITE    3'h5

// Timing: first halt release within 10 us + 2 clocks
`define FSPC_CLK_HZ       10000000
`define FSPC_REL_NS       10000
`define FSPC_REL_EXTRA    2
`define FSPC_OP_CYC       16

// AXI responses
`define FSPC_RESP_OKAY    2'h0
`define FSPC_RESP_SLVERR  2'h2

`endif

// *** hw/fspc_pkg.sv ***
/*
 * Types shared by the flash self-program control.
 * Assumes the constants header is included where numbers are needed.
 */
`default_nettype none
package fspc_pkg;
  // Unlock tracker, Gray coded along the key-val-inv-val path
  typedef enum logic [1:0] {
    FSPC_IDLE = 2'b00,
    FSPC_KEYD = 2'b01,
    FSPC_VAL1 = 2'b11,
    FSPC_INV  = 2'b10
  } fspc_seq_e;

  // Flash sequencer states
  typedef enum logic [1:0] {
    FSPC_RUN  = 2'b00,
    FSPC_BUSY = 2'b01,
    FSPC_DONE = 2'b11
  } fspc_op_e;

  // A peripheral store as seen by the tracker
  typedef struct packed {
    logic        valid;
    logic [15:0] idx;
    logic [7:0]  data;
  } fspc_store_s;
endpackage
`default_nettype wire

// *** testbench/fspc_flash_model.sv ***
/*
 * Flash array stand-in facing the self-program control.
 * Assumes one pulse on flash_start per operation, on aclk.
 */
`default_nettype none
module fspc_flash_model #(
  parameter int DLY = 8  // Operation length in cycles
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic flash_start,
  output logic      flash_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;  // Cycles left in the running operation

  // Answer each start with one done pulse DLY cycles later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt        <= 0;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (cnt == 1);
      if (flash_start) begin
        cnt <= DLY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/flash_self_program_control_test.sv ***
/*
 * Self-checking bench for the flash self-program control.
 * Assumes the design header on the include path and the flash model.
 */
`default_nettype none
`include "fspc_regs.svh"
module flash_self_program_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RC  = 300 / 100 + `FSPC_REL_EXTRA;  // First release bound
  localparam int DLY = 8;                            // Flash op length
  localparam logic [15:0] KI = `FSPC_IDX_KEY;
  localparam logic [15:0] SI = `FSPC_IDX_STATUS;
  localparam logic [15:0] MI = `FSPC_IDX_MODE;
  localparam logic [15:0] CI = `FSPC_IDX_CMD;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, halt_req, irq_in;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq_out, cpu_stall, pin_freeze, ram_block;
  logic flash_start, flash_done;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [4:0]  prot_byte;
  logic [2:0]  flash_cmd;
  logic [7:0]  blank_value;
  logic [15:0] prot_loc;
  logic        fs, rb;
  int          n, n_fail, checked;

  // Short release count keeps the run brief
  fspc_top #(.REL_NS(300)) uut (.*);
  fspc_flash_model #(.DLY(DLY)) flash (.*);

  // 10 MHz clock
  always #50 aclk = ~aclk;

  task automatic report_and_stop;
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare and count
  task automatic ck(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask

  // A wait that ran out ends the run
  task automatic lim(input int k, input int m);
    if (k >= m) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  // One AXI4-Lite write of a byte register
  task automatic wr(input logic [15:0] i, input logic [7:0] v);
    int k;
    k = 0;
    s_axi_awaddr  <= {i, 2'b00};
    s_axi_wdata   <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin @(posedge aclk); k++; end
    while (!(s_axi_awready && s_axi_wready) && k < 60);
    lim(k, 60);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do begin @(posedge aclk); k++; end
    while (s_axi_bvalid !== 1'b1 && k < 60);
    lim(k, 60);
    // bready stays up, so the response is taken at this edge; each write drives it high again
    ck("bresp", s_axi_bresp, `FSPC_RESP_OKAY);
  endtask

  // One AXI4-Lite read, data and response out
  task automatic rd(input logic [15:0] i, output logic [31:0] v,
                    output logic [1:0] e);
    int k;
    k = 0;
    s_axi_araddr  <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin @(posedge aclk); k++; end
    while (s_axi_arready !== 1'b1 && k < 60);
    lim(k, 60);
    s_axi_arvalid <= 1'b0;
    do begin @(posedge aclk); k++; end
    while (s_axi_rvalid !== 1'b1 && k < 60);
    lim(k, 60);
    // Data taken at the handshake edge; rready stays up between reads
    v = s_axi_rdata;
    e = s_axi_rresp;
  endtask

  // Key, value, inverse, value
  task automatic unlock(input logic [7:0] v);
    wr(KI, `FSPC_KEY_VAL);
    wr(MI, v);
    wr(MI, ~v);
    wr(MI, v);
  endtask

  // HALT for one cycle, count stalled cycles
  task automatic hlt(output int k, output logic f, output logic b);
    k = 0;
    b = 1'b0;
    halt_req <= 1'b1;
    #1 f = flash_start;
    @(posedge aclk);
    halt_req <= 1'b0;
    #1;
    while (cpu_stall === 1'b1 && k < 300) begin
      b = b | ram_block;
      @(posedge aclk);
      #1;
      k++;
    end
    lim(k, 300);
    @(posedge aclk);
  endtask

  initial begin
    aclk = 0; aresetn = 0; halt_req = 0; irq_in = 1; prot_byte = 5'h15;
    s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0;
    s_axi_arvalid = 0; s_axi_rready = 0; s_axi_wstrb = 4'hf;
    s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0;
    n_fail = 0; checked = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(MI, d, r); ck("mode", d, 32'h54);
    rd(SI, d, r); ck("status", d, 32'h0);
    ck("blank", blank_value, 8'hff);
    ck("protloc", prot_loc, 16'h0081);
    // Bare store, then wrong inverse, then foreign store
    wr(MI, 8'h01);
    rd(MI, d, r); ck("mode", d, 32'h54);
    rd(SI, d, r); ck("status", d, 32'h1);
    wr(SI, 8'h00);
    rd(SI, d, r); ck("status", d, 32'h0);
    wr(KI, 8'ha5); wr(MI, 8'h01); wr(MI, 8'h01); wr(MI, 8'h01);
    rd(MI, d, r); ck("mode", d, 32'h54);
    rd(SI, d, r); ck("status", d, 32'h1);
    wr(SI, 8'h00);
    wr(KI, 8'ha5); wr(CI, 8'h00);
    rd(SI, d, r); ck("status", d, 32'h1);
    wr(SI, 8'h00);
    // Enter self mode
    // CPU side masks interrupts; irq_in stays up to probe the gate
    irq_in <= 1'b1;
    // Address pointers sit outside this block and are left cleared
    wr(CI, 8'h00);
    unlock(8'h01);
    rd(MI, d, r); ck("mode", d, 32'h55);
    rd(SI, d, r); ck("status", d, 32'h0);
    ck("freeze", pin_freeze, 1'b1);
    ck("irq", irq_out, 1'b0);
    hlt(n, fs, rb);
    ck("first", n > 0 && n <= RC, 1'b1);
    ck("start", fs, 1'b0);
    repeat (80) @(posedge aclk);
    // Erase then write, each run by HALT
    wr(CI, `FSPC_CMD_ERASE);
    ck("cmd", flash_cmd, `FSPC_CMD_ERASE);
    hlt(n, fs, rb);
    ck("start", fs, 1'b1);
    ck("ramblk", rb, 1'b1);
    ck("busy", n >= DLY && n <= DLY + 4, 1'b1);
    wr(CI, `FSPC_CMD_WRITE);
    hlt(n, fs, rb);
    ck("start", fs, 1'b1);
    ck("busy", n >= DLY && n <= DLY + 4, 1'b1);
    // A change without a fresh key is refused
    wr(MI, 8'h00);
    rd(MI, d, r); ck("mode", d, 32'h55);
    rd(SI, d, r); ck("status", d, 32'h1);
    wr(SI, 8'h00);
    // Leave self mode
    wr(CI, 8'h00);
    unlock(8'h00);
    rd(MI, d, r); ck("mode", d, 32'h54);
    ck("irq", irq_out, 1'b1);
    ck("freeze", pin_freeze, 1'b0);
    hlt(n, fs, rb);
    ck("start", fs, 1'b0);
    ck("stall", n, 32'h0);
    // Unmapped place and the write-only key
    rd(16'hff90, d, r);
    ck("resp", r, `FSPC_RESP_SLVERR);
    ck("data", d, 32'h0);
    rd(KI, d, r); ck("key", d, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
